// File: jfa_defs.vh
// constants for the test-port flash access block
// assumes inclusion by the design and the bench, guarded against repeats
`ifndef JFA_DEFS_VH
`define JFA_DEFS_VH
// ----------------------------------------------------------------
// shift word layout
// ----------------------------------------------------------------
`define JFA_DR_W 20
`define JFA_OPC_HI 19
`define JFA_OPC_LO 18
`define JFA_WDATA_MSB 17
`define JFA_OPC_READ 2'h2
`define JFA_OPC_WRITE 2'h3
// ----------------------------------------------------------------
// instruction register and indirect target codes
// ----------------------------------------------------------------
`define JFA_IR_W 4
`define JFA_IR_CAPTURE 4'h1
`define JFA_IR_RESET 4'hf
`define JFA_SEL_CTRL 4'h4
`define JFA_SEL_DATA 4'h5
`define JFA_SEL_ADDR 4'h6
`define JFA_SEL_DEBUG 4'h8
// ----------------------------------------------------------------
// register fields and reset values
// ----------------------------------------------------------------
`define JFA_CTRL_RST 8'h00
`define JFA_ADDR_RST 16'h0000
`define JFA_DATA_RST 8'h00
`define JFA_CTRL_SCRATCH 7
`define JFA_WRMD_NONE 3'h0
`define JFA_WRMD_PROG 3'h1
`define JFA_WRMD_ERASE 3'h2
`define JFA_RDMD_NONE 4'h0
`define JFA_RDMD_BLOCK 4'h1
`define JFA_RDMD_SINGLE 4'h2
`define JFA_ERASE_KEY 8'ha5
// ----------------------------------------------------------------
// flash command codes
// ----------------------------------------------------------------
`define JFA_FCMD_READ 2'h0
`define JFA_FCMD_PROG 2'h1
`define JFA_FCMD_ERASE 2'h2
`endif

// File: jfa_regs.v
// test-port flash access registers and debug halt control
// assumes the test pins come from outside and a flash macro on ref_clk
`include "jfa_defs.vh"
module jfa_regs (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // test access port pins
  input wire tck,
  input wire tms,
  input wire tdi,
  output wire tdo,
  output wire tdo_oe,
  // flash macro port
  output wire fl_req,
  output wire [1:0] fl_cmd,
  output wire [15:0] fl_addr,
  output wire [7:0] fl_wdata,
  output wire fl_scratch,
  input wire fl_done,
  input wire fl_fail,
  input wire [7:0] fl_rdata,
  // core debug control
  input wire core_halted,
  input wire core_stepping,
  output wire core_halt_req,
  output wire core_step,
  output wire watchdog_suspend,
  output wire periph_run
);
  // tap states
  localparam ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3;
  localparam ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PAU_DR = 4'h6, ST_EX2_DR = 4'h7;
  localparam ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb;
  localparam ST_EX1_IR = 4'hc, ST_PAU_IR = 4'hd, ST_EX2_IR = 4'he, ST_UPD_IR = 4'hf;

  // ----------------------------------------------------------------
  // pin synchronisers and test clock edges
  // ----------------------------------------------------------------
  reg [2:0] tck_sync_ff;
  reg [1:0] tms_sync_ff;
  reg [1:0] tdi_sync_ff;
  wire tck_rise = tck_sync_ff[1] & ~tck_sync_ff[2];
  wire tck_fall = ~tck_sync_ff[1] & tck_sync_ff[2];
  wire tms_s = tms_sync_ff[1];
  wire tdi_s = tdi_sync_ff[1];

  // two stages per pin, third tck stage for edge finding
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_sync_ff <= 3'h0;
      tms_sync_ff <= 2'h3;
      tdi_sync_ff <= 2'h3;
    end else begin
      tck_sync_ff <= {tck_sync_ff[1:0], tck};
      tms_sync_ff <= {tms_sync_ff[0], tms};
      tdi_sync_ff <= {tdi_sync_ff[0], tdi};
    end
  end

  // ----------------------------------------------------------------
  // tap controller
  // ----------------------------------------------------------------
  reg [3:0] tap_ff;
  reg [3:0] nxt_tap;

  // standard sixteen-state walk on tms
  always @* begin
    nxt_tap = tap_ff;
    case (tap_ff)
      ST_RESET: nxt_tap = tms_s ? ST_RESET : ST_IDLE;
      ST_IDLE: nxt_tap = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: nxt_tap = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: nxt_tap = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: nxt_tap = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: nxt_tap = tms_s ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: nxt_tap = tms_s ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: nxt_tap = tms_s ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: nxt_tap = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: nxt_tap = tms_s ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: nxt_tap = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: nxt_tap = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: nxt_tap = tms_s ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: nxt_tap = tms_s ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: nxt_tap = tms_s ? ST_UPD_IR : ST_SH_IR;
      default: nxt_tap = tms_s ? ST_SEL_DR : ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg [`JFA_IR_W-1:0] ir_sh_ff;
  reg [`JFA_IR_W-1:0] ir_ff;
  reg [`JFA_DR_W-1:0] dr_sh_ff;
  reg tdo_ff;
  reg tdo_oe_ff;
  reg [7:0] ctrl_ff;
  reg [15:0] addr_ff;
  reg [7:0] data_ff;
  reg fail_ff;
  reg busy_ff;
  reg unread_ff;
  reg [1:0] cmd_ff;
  reg halt_req_ff;
  reg step_ff;
  reg wdt_susp_ff;

  wire [2:0] wr_mode = ctrl_ff[6:4];
  wire [3:0] rd_mode = ctrl_ff[3:0];
  wire [9:0] data_reg = {data_ff, fail_ff, busy_ff};
  wire [1:0] opc = dr_sh_ff[`JFA_OPC_HI:`JFA_OPC_LO];
  wire [7:0] wbyte = dr_sh_ff[`JFA_WDATA_MSB -: 8];
  wire upd_dr = tck_rise && (tap_ff == ST_UPD_DR);
  wire cap_dr = tck_rise && (tap_ff == ST_CAP_DR);
  wire sel_data = (ir_ff == `JFA_SEL_DATA);

  // right-justified read data for the selected target
  reg [17:0] rd_word;
  always @* begin
    rd_word = 18'h00000;
    if (ir_ff == `JFA_SEL_CTRL) begin
      rd_word = {10'h000, ctrl_ff};
    end else if (ir_ff == `JFA_SEL_DATA) begin
      rd_word = {8'h00, data_reg};
    end else if (ir_ff == `JFA_SEL_ADDR) begin
      rd_word = {2'h0, addr_ff};
    end else if (ir_ff == `JFA_SEL_DEBUG) begin
      rd_word = {14'h0000, core_stepping, core_halted, halt_req_ff, 1'b0};
    end
  end

  // commands accepted only while idle
  wire go_write = upd_dr && (opc == `JFA_OPC_WRITE) && !busy_ff;
  wire go_read = upd_dr && (opc == `JFA_OPC_READ) && !busy_ff;
  wire start_prog = go_write && sel_data && (wr_mode == `JFA_WRMD_PROG);
  wire start_erase = go_write && sel_data && (wr_mode == `JFA_WRMD_ERASE)
    && (wbyte == `JFA_ERASE_KEY);
  wire start_read = go_read && sel_data && ((rd_mode == `JFA_RDMD_BLOCK)
    || ((rd_mode == `JFA_RDMD_SINGLE) && !unread_ff));

  // ----------------------------------------------------------------
  // tap shifting and tdo launch on falling test clock
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_ff <= ST_RESET;
      ir_sh_ff <= `JFA_IR_RESET;
      ir_ff <= `JFA_IR_RESET;
      dr_sh_ff <= {`JFA_DR_W{1'b0}};
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      if (tck_rise) begin
        tap_ff <= nxt_tap;
        if (tap_ff == ST_RESET) begin
          ir_ff <= `JFA_IR_RESET;
        end else if (tap_ff == ST_CAP_IR) begin
          ir_sh_ff <= `JFA_IR_CAPTURE;
        end else if (tap_ff == ST_SH_IR) begin
          ir_sh_ff <= {tdi_s, ir_sh_ff[`JFA_IR_W-1:1]};
        end else if (tap_ff == ST_UPD_IR) begin
          ir_ff <= ir_sh_ff;
        end else if (tap_ff == ST_CAP_DR) begin
          dr_sh_ff <= {1'b0, rd_word, busy_ff};
        end else if (tap_ff == ST_SH_DR) begin
          dr_sh_ff <= {tdi_s, dr_sh_ff[`JFA_DR_W-1:1]};
        end
      end
      if (tck_fall) begin
        tdo_oe_ff <= (tap_ff == ST_SH_DR) || (tap_ff == ST_SH_IR);
        tdo_ff <= (tap_ff == ST_SH_IR) ? ir_sh_ff[0] : dr_sh_ff[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // indirect registers and flash sequencing
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= `JFA_CTRL_RST;
      addr_ff <= `JFA_ADDR_RST;
      data_ff <= `JFA_DATA_RST;
      fail_ff <= 1'b0;
      busy_ff <= 1'b0;
      unread_ff <= 1'b0;
      cmd_ff <= `JFA_FCMD_READ;
      halt_req_ff <= 1'b0;
      step_ff <= 1'b0;
    end else begin
      step_ff <= 1'b0;
      if (busy_ff && fl_done) begin
        // result and fail land in the same edge busy drops
        fail_ff <= fl_fail;
        busy_ff <= 1'b0;
        if (cmd_ff == `JFA_FCMD_READ) begin
          data_ff <= fl_rdata;
          unread_ff <= 1'b1;
        end
        if (cmd_ff != `JFA_FCMD_ERASE) begin
          addr_ff <= addr_ff + 16'h0001;
        end
      end else if (go_write) begin
        if (ir_ff == `JFA_SEL_CTRL) begin
          ctrl_ff <= wbyte;
        end else if (ir_ff == `JFA_SEL_ADDR) begin
          addr_ff <= dr_sh_ff[`JFA_WDATA_MSB -: 16];
        end else if (ir_ff == `JFA_SEL_DATA) begin
          data_ff <= wbyte;
        end else if (ir_ff == `JFA_SEL_DEBUG) begin
          halt_req_ff <= dr_sh_ff[`JFA_WDATA_MSB];
          step_ff <= dr_sh_ff[`JFA_WDATA_MSB-1];
        end
        if (start_prog || start_erase) begin
          busy_ff <= 1'b1;
          cmd_ff <= start_prog ? `JFA_FCMD_PROG : `JFA_FCMD_ERASE;
        end
      end else if (start_read) begin
        busy_ff <= 1'b1;
        cmd_ff <= `JFA_FCMD_READ;
      end else if (cap_dr && sel_data && !busy_ff) begin
        unread_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // debug side effects
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_susp_ff <= 1'b0;
    end else begin
      wdt_susp_ff <= core_halted | core_stepping;
    end
  end

  // outputs
  assign tdo = tdo_ff;
  assign tdo_oe = tdo_oe_ff;
  assign fl_req = busy_ff;
  assign fl_cmd = cmd_ff;
  assign fl_addr = addr_ff;
  assign fl_wdata = data_ff;
  assign fl_scratch = ctrl_ff[`JFA_CTRL_SCRATCH];
  assign core_halt_req = halt_req_ff;
  assign core_step = step_ff;
  assign watchdog_suspend = wdt_susp_ff;
  assign periph_run = 1'b1;
endmodule // jfa_regs

// File: jfa_regs_asserts.sv
// checker for the test-port flash access block
// assumes binding to jfa_regs; sees only its ports
module jfa_regs_asserts (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // flash macro port
  input wire fl_req,
  input wire [1:0] fl_cmd,
  input wire [15:0] fl_addr,
  input wire [7:0] fl_wdata,
  input wire fl_done,
  // core debug control
  input wire core_halted,
  input wire core_stepping,
  input wire core_step,
  input wire watchdog_suspend,
  input wire periph_run
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_REQ_HOLD: assert property (
    fl_req && !fl_done |=> fl_req && $stable(fl_cmd) && $stable(fl_addr) && $stable(fl_wdata))
    else $error("flash request moved before done");
  AST_DONE_ENDS: assert property (
    fl_req && fl_done |=> !fl_req) else $error("busy held after done");
  AST_ADDR_INC: assert property (
    fl_req && fl_done && fl_cmd != 2'h2 |=> fl_addr == $past(fl_addr) + 16'h0001)
    else $error("address not advanced");
  AST_ERASE_KEEP: assert property (
    fl_req && fl_done && fl_cmd == 2'h2 |=> $stable(fl_addr)) else $error("erase moved address");
  AST_ERASE_KEY: assert property (
    $rose(fl_req) && fl_cmd == 2'h2 |-> fl_wdata == 8'ha5) else $error("erase without key");
  AST_WDOG_ON: assert property (
    core_halted || core_stepping |=> watchdog_suspend) else $error("watchdog not suspended");
  AST_WDOG_OFF: assert property (
    !core_halted && !core_stepping |=> !watchdog_suspend) else $error("watchdog held");
  AST_PERIPH: assert property (
    periph_run) else $error("peripherals stopped");
  AST_STEP_PULSE: assert property (
    core_step |=> !core_step) else $error("step longer than one cycle");
  // main scenarios
  COV_PROG: cover property (fl_req && fl_done && fl_cmd == 2'h1);
  COV_ERASE: cover property (fl_req && fl_done && fl_cmd == 2'h2);
  COV_STEP: cover property (core_step);
endmodule // jfa_regs_asserts

// File: jfa_host.sv
// test access port host model
// assumes ref_clk from the bench; tck is 8 ref_clk a period, low between scans
module jfa_host (
  // system clock
  input wire ref_clk,
  // test access port
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire tdo
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle pins
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one tck period of 8 ref_clk, 4 low and 4 high, tdo taken mid high phase
  task cyc(input logic t, input logic d, output logic o);
    @(posedge ref_clk);
    tms <= t;
    tdi <= d;
    repeat (3) @(posedge ref_clk);
    tck <= 1'b1;
    repeat (2) @(posedge ref_clk);
    o = tdo;
    repeat (2) @(posedge ref_clk);
    tck <= 1'b0;
  endtask
  // idle to idle through one scan, lsb first
  task scan(input logic ir, input logic [19:0] din, input int n, output logic [19:0] dout);
    logic o;
    dout = 20'h0;
    cyc(1'b1, 1'b0, o);
    if (ir) cyc(1'b1, 1'b0, o);
    cyc(1'b0, 1'b0, o);
    cyc(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i], o);
      dout[i] = o;
    end
    cyc(1'b1, 1'b0, o);
    cyc(1'b0, 1'b0, o);
  endtask
  // five tms-high periods reach test-logic-reset
  task tap_reset();
    logic o;
    repeat (5) cyc(1'b1, 1'b0, o);
    cyc(1'b0, 1'b0, o);
  endtask
endmodule // jfa_host

// File: tb_top.sv
// self-checking bench for the test-port flash access block
// assumes jfa_regs, jfa_host and jfa_regs_asserts are compiled first
`include "jfa_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst_n = 1'b0, tck, tms, tdi, tdo, tdo_oe, fl_req, fl_scratch;
  logic core_halt_req, core_step, watchdog_suspend, periph_run, req_q = 1'b0;
  logic fl_done = 1'b0, fl_fail = 1'b0, fail_cfg = 1'b0;
  logic core_halted = 1'b0, core_stepping = 1'b0;
  logic [1:0] fl_cmd, last_cmd;
  logic [15:0] fl_addr, last_addr;
  logic [7:0] fl_wdata, last_wdata, fl_rdata = 8'h00, rd_byte = 8'h00;
  logic [19:0] w;
  int errors = 0, tests_run = 0, dly = 3, cnt = 0, starts = 0, steps = 0, oe_cyc = 0;
  jfa_regs i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .fl_req(fl_req), .fl_cmd(fl_cmd), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .fl_scratch(fl_scratch), .fl_done(fl_done), .fl_fail(fl_fail),
    .fl_rdata(fl_rdata), .core_halted(core_halted), .core_stepping(core_stepping),
    .core_halt_req(core_halt_req), .core_step(core_step),
    .watchdog_suspend(watchdog_suspend), .periph_run(periph_run));
  jfa_host i_host (.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // flash macro: done after dly+1 request cycles, lines churn when not answering
  always @(posedge ref_clk) begin
    req_q <= fl_req;
    fl_done <= 1'b0;
    fl_fail <= ~fl_fail;
    fl_rdata <= ~fl_rdata;
    if (core_step === 1'b1) steps <= steps + 1;
    if (tdo_oe === 1'b1) oe_cyc <= oe_cyc + 1;
    if (fl_req && !req_q) begin
      starts <= starts + 1;
      last_cmd <= fl_cmd;
      last_addr <= fl_addr;
      last_wdata <= fl_wdata;
    end
    if (fl_req && !fl_done) cnt <= cnt + 1;
    if (fl_req && !fl_done && cnt == dly) begin
      fl_done <= 1'b1;
      fl_fail <= fail_cfg;
      fl_rdata <= rd_byte;
      cnt <= 0;
    end
  end
  task chk(input string n, input logic [19:0] s, e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task complete_run();
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task wr(input logic [3:0] sel, input logic [17:0] d);
    i_host.scan(1'b1, {16'h0, sel}, 4, w);
    i_host.scan(1'b0, {2'b11, d}, 20, w);
  endtask
  task poll();
    for (int i = 0; i < 40; i++) begin
      i_host.scan(1'b0, 20'h0, 20, w);
      if (w[0] === 1'b0) return;
    end
    errors++;
    complete_run();
  endtask
  task t_program();
    wr(`JFA_SEL_ADDR, {16'h1234, 2'b00});
    chk("addr", fl_addr, 16'h1234);
    i_host.scan(1'b0, 20'h0, 20, w);
    chk("addr read", w[16:1], 16'h1234);
    chk("oe idle", tdo_oe, 1'b0);
    chk("oe shift", oe_cyc > 0, 1'b1);
    wr(`JFA_SEL_CTRL, {8'h90, 10'h0});
    chk("scratch on", fl_scratch, 1'b1);
    wr(`JFA_SEL_DATA, {8'h3c, 10'h0});
    poll();
    chk("cmd", last_cmd, 2'h1);
    chk("wdata", last_wdata, 8'h3c);
    chk("op addr", last_addr, 16'h1234);
    chk("addr inc", fl_addr, 16'h1235);
  endtask
  task t_fail_busy();
    int s0;
    dly = 700;
    fail_cfg = 1'b1;
    s0 = starts;
    i_host.scan(1'b0, {2'b11, 8'h81, 10'h0}, 20, w);
    i_host.scan(1'b0, 20'h0, 20, w);
    chk("busy", w[0], 1'b1);
    i_host.scan(1'b0, {2'b11, 8'h55, 10'h0}, 20, w);
    poll();
    i_host.scan(1'b0, {2'b10, 18'h0}, 20, w);
    poll();
    chk("starts", starts, s0 + 1);
    chk("fail", w[2], 1'b1);
    chk("byte kept", w[10:3], 8'h81);
    chk("addr after fail", fl_addr, 16'h1236);
    dly = 3;
    fail_cfg = 1'b0;
  endtask
  task t_erase_read();
    int s0;
    wr(`JFA_SEL_CTRL, {8'h20, 10'h0});
    chk("scratch off", fl_scratch, 1'b0);
    s0 = starts;
    wr(`JFA_SEL_DATA, {8'h5a, 10'h0});
    chk("no key", starts, s0);
    i_host.scan(1'b0, {2'b11, 8'ha5, 10'h0}, 20, w);
    poll();
    chk("erase cmd", last_cmd, 2'h2);
    chk("erase addr", fl_addr, 16'h1236);
    for (int m = 1; m < 3; m++) begin
      rd_byte = 8'h96 ^ m[7:0];
      wr(`JFA_SEL_CTRL, {8'h00 | m[7:0], 10'h0});
      i_host.scan(1'b1, {16'h0, 4'(`JFA_SEL_DATA)}, 4, w);
      i_host.scan(1'b0, {2'b10, 18'h0}, 20, w);
      poll();
      chk("rd cmd", last_cmd, 2'h0);
      chk("rd data", w[10:3], rd_byte);
      chk("fail clear", w[2], 1'b0);
      chk("rd addr", fl_addr, 16'h1236 + 16'(m));
      if (m == 2) begin
        // second read captured while busy, first completes mid-shift: refused
        dly = 100;
        s0 = starts;
        i_host.scan(1'b0, {2'b10, 18'h0}, 20, w);
        i_host.scan(1'b0, {2'b10, 18'h0}, 20, w);
        poll();
        chk("single refused", starts, s0 + 1);
        chk("single addr", fl_addr, 16'h1239);
        dly = 3;
      end
    end
  endtask
  task t_debug();
    wr(`JFA_SEL_DEBUG, 18'h20000);
    chk("halt req", core_halt_req, 1'b1);
    wr(`JFA_SEL_DEBUG, 18'h30000);
    repeat (2) @(posedge ref_clk);
    chk("step", steps, 1);
    core_halted <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("wdog halt", watchdog_suspend, 1'b1);
    i_host.scan(1'b0, 20'h0, 20, w);
    chk("debug read", w[4:2], 3'h3);
    core_halted <= 1'b0;
    core_stepping <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("wdog step", watchdog_suspend, 1'b1);
    core_stepping <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("wdog run", watchdog_suspend, 1'b0);
    chk("periph", periph_run, 1'b1);
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("reset addr", fl_addr, 16'h0000);
    chk("reset busy", fl_req, 1'b0);
    i_host.tap_reset();
    t_program();
    t_fail_busy();
    t_erase_read();
    t_debug();
    complete_run();
  end
endmodule // tb_top
bind jfa_regs jfa_regs_asserts i_chk (.ref_clk(ref_clk), .rst_n(rst_n), .fl_req(fl_req),
  .fl_cmd(fl_cmd), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_done(fl_done),
  .core_halted(core_halted), .core_stepping(core_stepping), .core_step(core_step),
  .watchdog_suspend(watchdog_suspend), .periph_run(periph_run));
